// file: rtl/disk_maint_cmd.sv
`timescale 1ns/100ps
`default_nettype none
`include "disk_maint_regs.svh"
module disk_maint_cmd
    import disk_maint_pkg::*;
#(
    parameter int SECTORS_PER_TRACK = 63
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cmd_wr_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  features_i,
    input  wire logic [7:0]  sector_num_i,
    input  wire logic [7:0]  cyl_low_i,
    input  wire logic [7:0]  cyl_high_i,
    input  wire logic [7:0]  drive_head_select_i,
    input  wire logic        data_wr_i,
    input  wire logic [15:0] data_i,
    input  wire logic        status_rd_i,
    input  wire logic        spindle_at_speed_i,
    input  wire logic        standby_i,
    input  wire logic        sleep_i,
    output logic             diag_start_o,
    input  wire logic        diag_done_i,
    input  wire logic [7:0]  diag_code_i,
    output logic             flush_start_o,
    input  wire logic        flush_done_i,
    output logic             track_start_o,
    output logic [27:0]      track_addr_o,
    output logic             track_lba_o,
    input  wire logic        track_done_i,
    input  wire logic        track_fault_i,
    input  wire logic        track_idnf_i,
    output logic             unit_start_o,
    input  wire logic        unit_done_i,
    input  wire logic        unit_fault_i,
    output logic [7:0]       command_status_flags_o,
    output logic [7:0]       command_error_flags_o,
    output logic [7:0]       sector_count_o,
    output logic [7:0]       sector_num_o,
    output logic [7:0]       cyl_low_o,
    output logic [7:0]       cyl_high_o,
    output logic [7:0]       drive_head_select_o,
    output logic             intrq_o
);
    function automatic cmd_op_e decode_op(input logic [7:0] code);
        cmd_op_e op;
        op = OP_NONE;
        if (code == `CMD_PWR_QUERY || code == `CMD_PWR_QUERY_ALT) begin
            op = OP_PWR;
        end else if (code == `CMD_DIAG) begin
            op = OP_DIAG;
        end else if (code == `CMD_FLUSH) begin
            op = OP_FLUSH;
        end else if (code == `CMD_FMT_TRACK) begin
            op = OP_TRACK;
        end else if (code == `CMD_FMT_UNIT) begin
            op = OP_UNIT;
        end else if (code == `CMD_ERASE_PREP) begin
            op = OP_PREP;
        end
        return op;
    endfunction : decode_op

    cmd_state_e  state_q, state_d;
    cmd_op_e     op_q, op_d;
    logic [7:0]  stat_q, stat_d;
    logic [7:0]  err_q, err_d;
    logic [7:0]  scnt_q, scnt_d;
    logic [7:0]  snum_q, snum_d;
    logic [7:0]  cyll_q, cyll_d;
    logic [7:0]  cylh_q, cylh_d;
    logic [7:0]  dh_q, dh_d;
    logic        irq_q, irq_d;
    logic        prep_q, prep_d;
    logic        bad_q, bad_d;
    logic [8:0]  words_q, words_d;
    logic        go_q, go_d;
    cmd_op_e     new_op;
    logic [8:0]  entries;

    assign new_op  = decode_op(cmd_code_i);
    // two table bytes per sector = one data word per entry
    assign entries = 9'(SECTORS_PER_TRACK);

    always_comb begin
        state_d = state_q;
        op_d    = op_q;
        stat_d  = stat_q;
        err_d   = err_q;
        scnt_d  = scnt_q;
        snum_d  = snum_q;
        cyll_d  = cyll_q;
        cylh_d  = cylh_q;
        dh_d    = dh_q;
        irq_d   = irq_q;
        prep_d  = prep_q;
        bad_d   = bad_q;
        words_d = words_q;
        go_d    = 1'b0;
        // clear on status read; a new completion below still wins
        if (status_rd_i) begin
            irq_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                // writes while busy are ignored, host must poll busy
                if (cmd_wr_i) begin
                    op_d   = new_op;
                    snum_d = sector_num_i;
                    cyll_d = cyl_low_i;
                    cylh_d = cyl_high_i;
                    dh_d   = drive_head_select_i;
                    err_d  = 8'h00;
                    bad_d  = 1'b0;
                    irq_d  = 1'b0;
                    stat_d = 8'h00;
                    stat_d[`STAT_BUSY_BIT] = 1'b1;
                    // prepare must be the very last command before unit fmt
                    prep_d = (new_op == OP_PREP);
                    state_d = ST_WORK;
                    go_d    = 1'b1;
                    if (new_op == OP_UNIT && (features_i != `FEAT_MERGE_DEFECT
                        || !prep_q)) begin
                        bad_d = 1'b1;
                        state_d = ST_DONE;
                    end else if (new_op == OP_NONE) begin
                        bad_d = 1'b1;
                        state_d = ST_DONE;
                    end else if (new_op == OP_TRACK) begin
                        words_d = 9'd0;
                        stat_d[`STAT_BUSY_BIT] = 1'b0;
                        stat_d[`STAT_DRQ_BIT]  = 1'b1;
                        state_d = ST_TABLE;
                    end
                end
            end
            ST_WORK: begin
                case (op_q)
                    OP_PWR: begin
                        scnt_d = (spindle_at_speed_i && !standby_i
                                  && !sleep_i) ? `PWR_ACTIVE_CODE
                                               : `PWR_IDLE_CODE;
                        state_d = ST_DONE;
                    end
                    OP_DIAG: begin
                        if (diag_done_i) begin
                            err_d   = diag_code_i;
                            state_d = ST_DONE;
                        end
                    end
                    OP_FLUSH: begin
                        if (flush_done_i) begin
                            state_d = ST_DONE;
                        end
                    end
                    OP_UNIT: begin
                        // media engine clears 0..native max, merges lists
                        if (unit_done_i) begin
                            err_d[`ERR_ABORT_BIT] = unit_fault_i;
                            state_d = ST_DONE;
                        end
                    end
                    default: state_d = ST_DONE;
                endcase
            end
            ST_TABLE: begin
                if (data_wr_i) begin
                    words_d = words_q + 9'd1;
                    // low byte is descriptor, high byte sector number
                    if (words_q < entries
                        && data_i[7:0] != `GOOD_DESCRIPTOR) begin
                        bad_d = 1'b1;
                    end
                    // tail words and sector numbers are not used
                    if (words_q == `TABLE_WORDS - 9'd1) begin
                        stat_d[`STAT_DRQ_BIT]  = 1'b0;
                        stat_d[`STAT_BUSY_BIT] = 1'b1;
                        state_d = (bad_d) ? ST_DONE : ST_MEDIA;
                        go_d    = ~bad_d;
                    end
                end
            end
            ST_MEDIA: begin
                // engine zeroes good sectors 1:1, no verify read
                if (track_done_i) begin
                    err_d[`ERR_ABORT_BIT] = track_fault_i;
                    err_d[`ERR_IDNF_BIT]  = track_idnf_i;
                    stat_d[`STAT_FAULT_BIT] = track_fault_i;
                    // address registers already hold the lba fields
                    if (dh_q[`DH_LBA_BIT]) begin
                        snum_d = snum_q;
                    end
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (bad_q) begin
                    err_d[`ERR_ABORT_BIT] = 1'b1;
                end
                stat_d = 8'h00;
                stat_d[`STAT_READY_BIT] = (op_q != OP_PWR) && (op_q != OP_DIAG);
                stat_d[`STAT_SEEK_BIT]  = (op_q != OP_PWR) && (op_q != OP_DIAG);
                stat_d[`STAT_FAULT_BIT] = stat_q[`STAT_FAULT_BIT];
                stat_d[`STAT_ERR_BIT]   = (op_q != OP_DIAG)
                    && (bad_q || err_q != 8'h00);
                // status and error valid together with interrupt
                irq_d   = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            op_q    <= OP_NONE;
            stat_q  <= `STATUS_RESET;
            err_q   <= 8'h00;
            scnt_q  <= 8'h00;
            snum_q  <= 8'h00;
            cyll_q  <= 8'h00;
            cylh_q  <= 8'h00;
            dh_q    <= 8'h00;
            irq_q   <= 1'b0;
            prep_q  <= 1'b0;
            bad_q   <= 1'b0;
            words_q <= 9'd0;
            go_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
            stat_q  <= stat_d;
            err_q   <= err_d;
            scnt_q  <= scnt_d;
            snum_q  <= snum_d;
            cyll_q  <= cyll_d;
            cylh_q  <= cylh_d;
            dh_q    <= dh_d;
            irq_q   <= irq_d;
            prep_q  <= prep_d;
            bad_q   <= bad_d;
            words_q <= words_d;
            go_q    <= go_d;
        end
    end

    assign diag_start_o  = go_q && state_q == ST_WORK && op_q == OP_DIAG;
    assign flush_start_o = go_q && state_q == ST_WORK && op_q == OP_FLUSH;
    assign unit_start_o  = go_q && state_q == ST_WORK && op_q == OP_UNIT;
    assign track_start_o = go_q && state_q == ST_MEDIA;
    // lba: sector 7:0, cyl low 15:8, cyl high 23:16, head 27:24
    assign track_addr_o  = {dh_q[3:0], cylh_q, cyll_q, snum_q};
    // whole logical track containing the address is formatted
    assign track_lba_o   = dh_q[`DH_LBA_BIT];
    assign command_status_flags_o = stat_q;
    assign command_error_flags_o  = err_q;
    assign sector_count_o         = scnt_q;
    assign sector_num_o           = snum_q;
    assign cyl_low_o              = cyll_q;
    assign cyl_high_o             = cylh_q;
    assign drive_head_select_o    = dh_q;
    assign intrq_o                = irq_q;
endmodule : disk_maint_cmd
`default_nettype wire

// file: rtl/disk_maint_regs.svh
// Function
// - decode command codes E5h and 98h both as power mode query
// - power query returns FFh when spun up and active, else zero
// - command 90h runs diagnostics; error register holds diagnostic code
// - E7h flushes write cache, then completes with status 50h
// - track format host sends one sector table, descriptor then number
// - descriptor 00h is good; any other value aborts with abort bit
// - bytes after the format table entries are ignored
// - good sectors written with zeros, no read-back verify
// - track always laid out at 1:1 interleave regardless of table
// - address mode bit zero selects CHS, one selects block addressing
// - block address from sector, cylinder low, cylinder high, head field
// - track format in block mode reports current address back
// - block mode formats the whole track holding the address
// - unit format aborts unless features register holds 11h
// - unit format aborts unless erase-prepare immediately preceded it
// - unit format clears block 0 through native maximum address
// - unit format merges reassigned list into defect list, erases old
// - unit format has no data transfer phase
// - status and error valid once busy cleared and interrupt raised
// - non-data command: set busy, on completion clear busy, interrupt
// - reading status register clears pending interrupt
// - invalid parameter aborts: busy clear, error and abort set, interrupt
`ifndef DISK_MAINT_REGS_SVH
`define DISK_MAINT_REGS_SVH
`define CMD_PWR_QUERY      8'he5
`define CMD_PWR_QUERY_ALT  8'h98
`define CMD_DIAG           8'h90
`define CMD_FLUSH          8'he7
`define CMD_FMT_TRACK      8'h50
`define CMD_FMT_UNIT       8'hf7
`define CMD_ERASE_PREP     8'hf3
`define FEAT_MERGE_DEFECT  8'h11
`define PWR_ACTIVE_CODE    8'hff
`define PWR_IDLE_CODE      8'h00
`define GOOD_DESCRIPTOR    8'h00
`define STAT_FLUSH_OK      8'h50
`define STAT_BUSY_BIT      7
`define STAT_READY_BIT     6
`define STAT_FAULT_BIT     5
`define STAT_SEEK_BIT      4
`define STAT_DRQ_BIT       3
`define STAT_ERR_BIT       0
`define ERR_ABORT_BIT      2
`define ERR_IDNF_BIT       4
`define DH_LBA_BIT         6
`define TABLE_WORDS        9'd256
`define STATUS_RESET       8'h50
`endif

// file: rtl/disk_maint_pkg.sv
package disk_maint_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WORK  = 3'b001,
        ST_TABLE = 3'b010,
        ST_MEDIA = 3'b011,
        ST_DONE  = 3'b100
    } cmd_state_e;
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_PWR   = 3'b001,
        OP_DIAG  = 3'b010,
        OP_FLUSH = 3'b011,
        OP_TRACK = 3'b100,
        OP_UNIT  = 3'b101,
        OP_PREP  = 3'b110
    } cmd_op_e;
endpackage : disk_maint_pkg

// file: verif/drive_backend_model.sv
`timescale 1ns/100ps
`default_nettype none
module drive_backend_model #(
    parameter int         DLY  = 20,
    parameter logic [7:0] CODE = 8'h01  // arbitrary diagnostic result
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] start_i,
    output logic [3:0]      done_o,
    output logic [7:0]      diag_code_o,
    output logic            fault_o
);
    int         cnt_q;
    logic [3:0] kind_q;
    // media jobs never fail here, so fault stays low
    assign fault_o     = 1'b0;
    assign diag_code_o = CODE;
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q  <= 0;
            kind_q <= 4'h0;
            done_o <= 4'h0;
        end else if (start_i != 4'h0) begin
            cnt_q  <= DLY;
            kind_q <= start_i;
            done_o <= 4'h0;
        end else if (cnt_q == 1) begin
            done_o <= kind_q;
            cnt_q  <= 0;
        end else begin
            done_o <= 4'h0;
            if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : drive_backend_model
`default_nettype wire

// file: verif/disk_maint_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module disk_maint_monitor (
    input wire logic       clk_i, sys_rst_i, cmd_wr_i, status_rd_i,
    input wire logic       spindle_at_speed_i, standby_i, sleep_i,
    input wire logic       diag_done_i, flush_done_i, flush_start_o, intrq_o,
    input wire logic [7:0] cmd_code_i, features_i, diag_code_i,
    input wire logic [7:0] command_status_flags_o, command_error_flags_o,
    input wire logic [7:0] sector_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic take, pwr;
    logic [7:0] st;
    assign st   = command_status_flags_o;
    assign take = cmd_wr_i && !st[7] && !st[3];
    assign pwr  = cmd_code_i == 8'he5 || cmd_code_i == 8'h98;
    // track format answers with a data request instead of busy
    take_busy_a: assert property (take && cmd_code_i != 8'h50 |=> st[7])
        else $error("busy not set after command");
    table_req_a: assert property (take && cmd_code_i == 8'h50 |=> st[3])
        else $error("data request not set for format table");
    pwr_code_a: assert property (take && pwr |-> ##2 sector_count_o ==
        ((spindle_at_speed_i && !standby_i && !sleep_i) ? 8'hff : 8'h00))
        else $error("power code wrong");
    pwr_done_a: assert property (take && pwr |-> ##3 intrq_o && !st[7])
        else $error("power query not completed");
    flush_ok_a: assert property (flush_done_i |-> ##2 st == 8'h50 && intrq_o)
        else $error("flush status wrong");
    flush_go_a: assert property (take && cmd_code_i == 8'he7 |=> flush_start_o)
        else $error("flush not started");
    diag_code_a: assert property (diag_done_i |-> ##2
        command_error_flags_o == $past(diag_code_i, 2))
        else $error("diag code wrong");
    feat_abort_a: assert property (take && cmd_code_i == 8'hf7 &&
        features_i != 8'h11 |-> ##2 st == 8'h51 &&
        command_error_flags_o == 8'h04 && intrq_o)
        else $error("unit format not aborted");
    irq_clear_a: assert property (status_rd_i && intrq_o && !st[7] |=>
        !intrq_o) else $error("interrupt not cleared");
    irq_idle_a: assert property ($rose(intrq_o) |-> !st[7] && !st[3])
        else $error("interrupt while busy");
    cover property (take && pwr);
    cover property (flush_done_i);
    cover property (take && cmd_code_i == 8'hf7);
endmodule : disk_maint_monitor
bind disk_maint_cmd disk_maint_monitor mon (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .cmd_wr_i(cmd_wr_i), .status_rd_i(status_rd_i),
    .spindle_at_speed_i(spindle_at_speed_i), .standby_i(standby_i),
    .sleep_i(sleep_i), .diag_done_i(diag_done_i), .intrq_o(intrq_o),
    .flush_done_i(flush_done_i), .flush_start_o(flush_start_o),
    .cmd_code_i(cmd_code_i), .features_i(features_i),
    .diag_code_i(diag_code_i), .sector_count_o(sector_count_o),
    .command_status_flags_o(command_status_flags_o),
    .command_error_flags_o(command_error_flags_o));
`default_nettype wire

// file: verif/disk_maint_cmd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module disk_maint_cmd_tb_top;
    localparam logic [7:0] DCODE = 8'h01;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, cmd_wr_i = 1'b0, data_wr_i = 1'b0;
    logic rd = 1'b0, spin = 1'b1, stby = 1'b0, slp = 1'b0, tlba, irq, flt;
    logic [7:0] code = 8'h00, feat = 8'h00, snum = 8'h00, cyll = 8'h00;
    logic [7:0] cylh = 8'h00, dh = 8'h00, dcode, sts, err, scnt;
    logic [7:0] snum_o, cyll_o, cylh_o, dh_o;
    logic [15:0] data = 16'h0000;
    logic [27:0] taddr;
    logic [3:0] go, dn;
    logic [16:0] tbl [11] = '{{16'hf711, 1'b1}, {16'hf300, 1'b0},
        {16'hf722, 1'b1}, {16'hf300, 1'b0}, {16'he700, 1'b0},
        {16'hf711, 1'b1}, {16'hf300, 1'b0}, {16'hf711, 1'b0},
        {16'ha500, 1'b1}, {16'h9000, 1'b0}, {16'he700, 1'b0}};
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    drive_backend_model #(.DLY(20), .CODE(DCODE)) back (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .start_i(go), .done_o(dn),
        .diag_code_o(dcode), .fault_o(flt));
    disk_maint_cmd uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cmd_wr_i(cmd_wr_i), .cmd_code_i(code), .features_i(feat),
        .sector_num_i(snum), .cyl_low_i(cyll), .cyl_high_i(cylh),
        .drive_head_select_i(dh), .data_wr_i(data_wr_i), .data_i(data),
        .status_rd_i(rd), .spindle_at_speed_i(spin), .standby_i(stby),
        .sleep_i(slp), .diag_start_o(go[0]), .diag_done_i(dn[0]),
        .diag_code_i(dcode), .flush_start_o(go[1]), .flush_done_i(dn[1]),
        .track_start_o(go[2]), .track_addr_o(taddr), .track_lba_o(tlba),
        .track_done_i(dn[2]), .track_fault_i(flt), .track_idnf_i(flt),
        .unit_start_o(go[3]), .unit_done_i(dn[3]), .unit_fault_i(flt),
        .command_status_flags_o(sts), .command_error_flags_o(err),
        .sector_count_o(scnt), .sector_num_o(snum_o), .cyl_low_o(cyll_o),
        .cyl_high_o(cylh_o), .drive_head_select_o(dh_o), .intrq_o(irq));
    task test_done();
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // host only writes while idle, one edge per request
    task issue(input logic [7:0] c, input logic [7:0] f);
        @(posedge clk_i);
        cmd_wr_i <= 1'b1;
        code     <= c;
        feat     <= f;
        @(posedge clk_i);
        cmd_wr_i <= 1'b0;
    endtask : issue
    task wait_irq();
        for (int i = 0; i < 2000 && irq !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(irq, 1'b1);
        chk(sts[7], 1'b0);
    endtask : wait_irq
    task ack();
        @(posedge clk_i);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(irq, 1'b0);
    endtask : ack
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({irq, sts}, 9'h050);
        for (int k = 0; k < 16; k++) begin
            spin <= k[0];
            stby <= k[1];
            slp  <= k[2];
            issue(k[3] ? 8'h98 : 8'he5, 8'h00);
            wait_irq();
            chk(scnt, (k[2:0] == 3'd1) ? 8'hff : 8'h00);
            ack();
        end
        foreach (tbl[i]) begin
            issue(tbl[i][16:9], tbl[i][8:1]);
            wait_irq();
            chk({sts[0], err[2], sts[3]}, {tbl[i][0], tbl[i][0], 1'b0});
            if (tbl[i][16:9] == 8'he7)
                chk(sts, 8'h50);
            if (tbl[i][16:9] == 8'h90)
                chk(err, DCODE);
            ack();
        end
        for (int m = 0; m < 3; m++) begin
            dh   <= (m == 1) ? 8'ha5 : 8'he5;
            snum <= 8'h12;
            cyll <= 8'h34;
            cylh <= 8'h56;
            issue(8'h50, 8'h00);
            for (int i = 0; i < 100 && sts[3] !== 1'b1; i++) @(posedge clk_i);
            chk(sts[3], 1'b1);
            for (int w = 0; w < 256; w++) begin
                @(posedge clk_i);
                data_wr_i <= 1'b1;
                data <= {w[7:0], (m == 2 && w == 5) ? 8'h07 :
                         (w > 62) ? 8'hff : 8'h00};
            end
            @(posedge clk_i);
            data_wr_i <= 1'b0;
            wait_irq();
            chk({sts[0], err[2]}, {2{m == 2}});
            if (m < 2)
                chk({tlba, taddr}, {m == 0, 28'h5563412});
            if (m == 0)
                chk({dh_o[3:0], cylh_o, cyll_o, snum_o}, 28'h5563412);
            ack();
        end
        test_done();
    end
endmodule : disk_maint_cmd_tb_top
`default_nettype wire
